/* File: design/htx_pkg.sv */
package htx_pkg;
  // Register word offsets on the APB bus (byte addresses)
  localparam logic [7:0]  OFS_TVAL_LO  = 8'h00;
  localparam logic [7:0]  OFS_TVAL_HI  = 8'h04;
  localparam logic [7:0]  OFS_TINST_LO = 8'h08;
  localparam logic [7:0]  OFS_TINST_HI = 8'h0c;
  localparam logic [7:0]  OFS_ROOT_LO  = 8'h10;
  localparam logic [7:0]  OFS_ROOT_HI  = 8'h14;

  // Root register layout, 32-bit form
  localparam int          R32_MODE_POS  = 31;
  localparam int          R32_TAG_LSB   = 22;
  localparam int          R32_TAG_MAX   = 7;
  localparam int          R32_FRAME_W   = 22;
  // Root register layout, 64-bit form
  localparam int          R64_MODE_LSB  = 60;
  localparam int          R64_TAG_LSB   = 44;
  localparam int          R64_TAG_MAX   = 14;
  localparam int          R64_FRAME_W   = 44;

  // Guest address shift into the trap value
  localparam int          GPA_SHIFT     = 2;

  // Mode encodings
  localparam logic [3:0]  MODE_NONE     = 4'h0;
  localparam logic [3:0]  MODE_P34      = 4'h1;
  localparam logic [3:0]  MODE_P41      = 4'h8;
  localparam logic [3:0]  MODE_P50      = 4'h9;
  localparam logic [3:0]  MODE_P59      = 4'ha;

  // Supported-mode masks, one bit per mode code
  localparam logic [15:0] SUP_MODES_32  = 16'h0003;
  localparam logic [15:0] SUP_MODES_64  = 16'h0701;

  // Reset values
  localparam logic [63:0] RST_WORD      = 64'h0;
  localparam logic [3:0]  RST_MODE      = 4'h0;

  // Decoded translation scheme
  typedef enum logic [2:0] {
    XL_NONE,
    XL_P34,
    XL_P41,
    XL_P50,
    XL_P59
  } htx_scheme_t;
endpackage : htx_pkg

/* File: design/htx_regs.sv */
`timescale 1ns/1ps
module htx_regs
  import htx_pkg::*;
#(
  parameter int          HYP_XLEN  = 64,
  parameter int          TAG_W     = (HYP_XLEN == 32) ? R32_TAG_MAX : R64_TAG_MAX,
  parameter int          GPA_W     = (HYP_XLEN == 32) ? 34 : 59,
  parameter logic [15:0] SUP_MODES = (HYP_XLEN == 32) ? htx_pkg::SUP_MODES_32 : htx_pkg::SUP_MODES_64
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Privilege context of the register access
  input  wire logic                  access_from_hs,
  input  wire logic                  trap_translation_access,
  output logic                       illegal_instr,
  // Trap unit
  input  wire logic                  trap_taken,
  input  wire logic                  trap_is_gpf,
  input  wire logic                  trap_report_gpa,
  input  wire logic                  trap_implicit,
  input  wire logic [63:0]           trap_gpa_access,
  input  wire logic [63:0]           trap_gpa_implicit,
  input  wire logic [63:0]           trap_inst_info,
  // Translation context
  input  wire logic                  eff_priv_user,
  input  wire logic                  hyp_user_access,
  output logic                       xlat_active,
  output logic                       xlat_direct,
  output htx_pkg::htx_scheme_t       xlat_scheme,
  output logic [3:0]                 xlat_mode,
  output logic [13:0]                xlat_machine_tag,
  output logic [43:0]                xlat_root_frame_number
);
  import htx_pkg::*;

  // Derived masks
  localparam bit          IS32      = (HYP_XLEN == 32);
  localparam logic [14:0] TAG_ONE   = 15'h1;
  localparam logic [13:0] TAG_MASK  = 14'((TAG_ONE << TAG_W) - TAG_ONE);
  localparam logic [64:0] GPA_ONE   = 65'h1;
  localparam logic [63:0] TVAL_MASK = 64'((GPA_ONE << (GPA_W - GPA_SHIFT)) - GPA_ONE);
  localparam logic [63:0] XMASK     = IS32 ? 64'h0000_0000_ffff_ffff : 64'hffff_ffff_ffff_ffff;
  localparam logic [43:0] FRAME_M32 = 44'h0000_03f_fffc;
  localparam logic [43:0] FRAME_M64 = 44'hfff_ffff_fffc;

  // Stored state
  logic [63:0]       tval;            // Trap value register
  logic [63:0]       tinst;           // Trap instruction register
  logic [3:0]        root_mode;       // Root mode field
  logic [13:0]       root_tag;        // Root machine_tag field
  logic [43:0]       root_frame;      // Root root_frame_number field

  // Address decode
  wire               hit_tval_lo  = (paddr == OFS_TVAL_LO);
  wire               hit_tval_hi  = (paddr == OFS_TVAL_HI) && !IS32;
  wire               hit_tinst_lo = (paddr == OFS_TINST_LO);
  wire               hit_tinst_hi = (paddr == OFS_TINST_HI) && !IS32;
  wire               hit_root_lo  = (paddr == OFS_ROOT_LO);
  wire               hit_root_hi  = (paddr == OFS_ROOT_HI) && !IS32;
  wire               hit_tval     = hit_tval_lo | hit_tval_hi;
  wire               hit_tinst    = hit_tinst_lo | hit_tinst_hi;
  wire               hit_root     = hit_root_lo | hit_root_hi;
  wire               mapped       = hit_tval | hit_tinst | hit_root;
  wire               upper        = paddr[2];

  // Gated root access from the hypervisor level
  wire               root_refused = hit_root & access_from_hs & trap_translation_access;

  // Bus phases
  wire               setup_ph     = psel & ~penable;
  wire               acc_done     = psel & penable & pready;
  wire               wr_ok        = acc_done & pwrite & mapped & ~root_refused;

  // Root register image as software sees it
  wire [63:0]        root_img32   = {32'h0, root_mode[0], 2'b00, root_tag[6:0], root_frame[21:0]};
  wire [63:0]        root_img64   = {root_mode, 2'b00, root_tag, root_frame};
  wire [63:0]        root_img     = IS32 ? root_img32 : root_img64;

  // Selected full word and its read half
  wire [63:0]        sel_word     = hit_tval ? tval : (hit_tinst ? tinst : root_img);
  wire [31:0]        rd_word      = (!mapped || root_refused) ? 32'h0 :
                                    (upper ? sel_word[63:32] : sel_word[31:0]);

  // Written half merged into the old word
  wire [63:0]        merged       = upper ? {pwdata, sel_word[31:0]} : {sel_word[63:32], pwdata};

  // Root fields pulled from the merged image
  wire [3:0]         wr_mode      = IS32 ? {3'b000, merged[R32_MODE_POS]} : merged[63:R64_MODE_LSB];
  wire [13:0]        wr_tag       = IS32 ? {7'h00, merged[R32_TAG_LSB +: R32_TAG_MAX]}
                                         : merged[R64_TAG_LSB +: R64_TAG_MAX];
  wire [43:0]        wr_frame     = IS32 ? {22'h0, merged[R32_FRAME_W-1:0]} : merged[R64_FRAME_W-1:0];

  // Per-field legalisation; a bad mode keeps the old one
  wire               mode_ok      = SUP_MODES[wr_mode];
  wire [3:0]         next_mode    = mode_ok ? wr_mode : root_mode;
  wire [13:0]        next_tag     = wr_tag & TAG_MASK;
  wire [43:0]        next_frame   = wr_frame & (IS32 ? FRAME_M32 : FRAME_M64);

  // Trap value chosen for a guest-page fault
  wire [63:0]        gpa_sel      = trap_implicit ? trap_gpa_implicit : trap_gpa_access;
  wire [63:0]        gpa_shifted  = (gpa_sel >> GPA_SHIFT) & TVAL_MASK & XMASK;
  wire [63:0]        trap_tval    = (trap_is_gpf && trap_report_gpa) ? gpa_shifted : 64'h0;

  // Translation scheme decode for the mode a root write will store (next_mode)
  htx_scheme_t       next_scheme;
  assign next_scheme = IS32 ? ((next_mode == MODE_P34) ? XL_P34 : XL_NONE) :
                       (next_mode == MODE_P41) ? XL_P41 :
                       (next_mode == MODE_P50) ? XL_P50 :
                       (next_mode == MODE_P59) ? XL_P59 : XL_NONE;

  // Root is live unless a user-level access lacks hypervisor user access
  wire               next_active  = ~(eff_priv_user & ~hyp_user_access);

  // APB answer: one access cycle, data and error prepared at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup_ph;
      prdata  <= (setup_ph && !pwrite) ? rd_word : 32'h0;
      pslverr <= setup_ph & (~mapped | root_refused);
    end
  end

  // Illegal-instruction pulse after a refused root access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      illegal_instr <= 1'b0;
    else
      illegal_instr <= acc_done & root_refused;
  end

  // Trap value register: trap wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tval <= RST_WORD;
    else if (trap_taken)
      tval <= trap_tval;
    else if (wr_ok && hit_tval)
      tval <= merged & TVAL_MASK & XMASK;
  end

  // Trap instruction register: trap wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tinst <= RST_WORD;
    else if (trap_taken)
      tinst <= trap_inst_info & XMASK;
    else if (wr_ok && hit_tinst)
      tinst <= merged & XMASK;
  end

  // Root register fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      root_mode  <= RST_MODE;
      root_tag   <= 14'h0;
      root_frame <= 44'h0;
    end
    else if (wr_ok && hit_root)
    begin
      root_mode  <= next_mode;
      root_tag   <= next_tag;
      root_frame <= next_frame;
    end
  end

  // Translation view of the root register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xlat_scheme <= XL_NONE;
      xlat_direct <= 1'b1;
      xlat_active <= 1'b0;
    end
    else
    begin
      xlat_active <= next_active;
      if (wr_ok && hit_root)
      begin
        xlat_scheme <= next_scheme;
        xlat_direct <= (next_mode == MODE_NONE);
      end
    end
  end

  // Field outputs straight from the stored flops
  assign xlat_mode              = root_mode;
  assign xlat_machine_tag       = root_tag;
  assign xlat_root_frame_number = root_frame;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_trap_clears_tval: assert property (
    trap_taken && !trap_is_gpf |=> tval == 64'h0)
    else $error("trap value not cleared on non-guest trap");

  a_gpf_loads_addr: assert property (
    trap_taken && trap_is_gpf && trap_report_gpa && !trap_implicit
    |=> tval == ($past(trap_gpa_access) >> GPA_SHIFT & TVAL_MASK & XMASK))
    else $error("guest fault address not loaded shifted");

  a_implicit_addr: assert property (
    trap_taken && trap_is_gpf && trap_report_gpa && trap_implicit
    |=> tval == ($past(trap_gpa_implicit) >> GPA_SHIFT & TVAL_MASK & XMASK))
    else $error("implicit access address not reported");

  a_trap_sets_inst: assert property (
    trap_taken |=> tinst == ($past(trap_inst_info) & XMASK))
    else $error("instruction info not written on trap");

  a_refuse_gated: assert property (
    acc_done && root_refused |-> pslverr ##1 (illegal_instr && $stable(root_img)))
    else $error("gated root access not refused");

  a_frame_low_zero: assert property (
    root_frame[1:0] == 2'b00)
    else $error("root frame low bits not zero");

  a_tag_width: assert property (
    (root_tag & ~TAG_MASK) == 14'h0)
    else $error("tag bit set above implemented width");

  a_mode_legal: assert property (
    wr_ok && hit_root && !mode_ok |=> $stable(root_mode) && root_tag == $past(next_tag))
    else $error("unsupported mode write mishandled");

  a_active_rule: assert property (
    eff_priv_user && !hyp_user_access |=> !xlat_active)
    else $error("root active for user without access");

  a_ready_once: assert property (
    setup_ph |=> pready ##1 !pready)
    else $error("answer not one access cycle");

  // A plain trap beats a same-cycle software write
  a_trap_beats_write: assert property (
    trap_taken && !trap_is_gpf && wr_ok && hit_tval |=> tval == 64'h0)
    else $error("software write beat a trap");

  // Guest fault without an address records zero
  a_gpf_zero_report: assert property (
    trap_taken && trap_is_gpf && !trap_report_gpa |=> tval == 64'h0)
    else $error("guest fault without address not zero");

  // Bits above the shifted guest address stay clear
  a_tval_top_zero: assert property (
    tval[63:GPA_W-GPA_SHIFT] == '0)
    else $error("trap value holds bits above address");

  // Zero written by software is kept unless a trap lands in the same cycle
  a_tval_holds_zero: assert property (
    wr_ok && hit_tval_lo && !trap_taken && pwdata == 32'h0
    |=> tval[31:0] == 32'h0)
    else $error("trap value cannot hold zero");

  // Software write to instruction info is stored
  a_tinst_write: assert property (
    wr_ok && hit_tinst_lo && !trap_taken
    |=> tinst[31:0] == $past(pwdata))
    else $error("instruction info write lost");

  // Illegal-instruction pulse only after a refused access
  a_illegal_cause: assert property (
    illegal_instr |-> $past(acc_done && root_refused))
    else $error("illegal instruction without refused access");

  // Upper root read shows mode and two zero bits
  a_root_hi_read: assert property (
    setup_ph && hit_root_hi && !pwrite && !root_refused
    |=> prdata[31:28] == $past(root_mode) && prdata[27:26] == 2'b00)
    else $error("root upper word layout wrong");

  // Frame bits above the aligned pair follow the write
  a_frame_write: assert property (
    wr_ok && hit_root_lo
    |=> root_frame[21:2] == $past(pwdata[21:2]))
    else $error("root frame write lost");

  // No translation decodes as direct
  a_scheme_none: assert property (
    root_mode == MODE_NONE |-> xlat_scheme == XL_NONE && xlat_direct)
    else $error("no translation decoded wrongly");

  // 34-bit paged decode in the narrow form
  a_scheme_p34: assert property (
    IS32 && root_mode == MODE_P34 |-> xlat_scheme == XL_P34 && !xlat_direct)
    else $error("34-bit paged mode decoded wrongly");

  // 41-bit paged decode
  a_scheme_p41: assert property (
    !IS32 && root_mode == MODE_P41 |-> xlat_scheme == XL_P41)
    else $error("41-bit paged mode decoded wrongly");

  // 50-bit paged decode
  a_scheme_p50: assert property (
    !IS32 && root_mode == MODE_P50 |-> xlat_scheme == XL_P50)
    else $error("50-bit paged mode decoded wrongly");

  // 59-bit paged decode
  a_scheme_p59: assert property (
    !IS32 && root_mode == MODE_P59 |-> xlat_scheme == XL_P59)
    else $error("59-bit paged mode decoded wrongly");

  // Stored mode is always a supported one
  a_mode_supported: assert property (
    SUP_MODES[root_mode])
    else $error("unsupported mode stored");

  // Lowest tag bit is the first implemented
  a_tag_lsb_first: assert property (
    !IS32 && wr_ok && hit_root_hi && pwdata[12]
    |=> (TAG_W == 0) || root_tag[0])
    else $error("tag not filled from bit zero");

  // All-ones tag probe returns the implemented bits
  a_tag_probe: assert property (
    !IS32 && wr_ok && hit_root_hi && pwdata[25:12] == 14'h3fff
    |=> root_tag == TAG_MASK)
    else $error("tag probe returned wrong bits");

  // Root live whenever the user exception is absent
  a_active_on: assert property (
    !(eff_priv_user && !hyp_user_access) |=> xlat_active)
    else $error("root inactive outside user exception");

  c_plain_trap:  cover property (trap_taken && !trap_is_gpf);
  c_gpf_trap:    cover property (trap_taken && trap_is_gpf && trap_report_gpa);
  c_refused:     cover property (acc_done && root_refused);
  c_bad_mode:    cover property (wr_ok && hit_root && !mode_ok);
  c_paged_write: cover property (wr_ok && hit_root && mode_ok && wr_mode != MODE_NONE);
endmodule : htx_regs

/* File: bench/htx_trap_src.sv */
`timescale 1ns/1ps
// Trap unit model: one-cycle trap pulses with qualifiers
module htx_trap_src
(
  input  wire logic        pclk,
  output logic             trap_taken,
  output logic             trap_is_gpf,
  output logic             trap_report_gpa,
  output logic             trap_implicit,
  output logic [63:0]      trap_gpa_access,
  output logic [63:0]      trap_gpa_implicit,
  output logic [63:0]      trap_inst_info
);
  // Idle values at time zero
  initial
  begin
    trap_taken        = 1'b0;
    trap_is_gpf       = 1'b0;
    trap_report_gpa   = 1'b0;
    trap_implicit     = 1'b0;
    trap_gpa_access   = 64'h0;
    trap_gpa_implicit = 64'h0;
    trap_inst_info    = 64'h0;
  end

  // One trap; buses show inverted data when idle
  task automatic fire(input logic g, input logic r, input logic m,
                      input logic [63:0] a, input logic [63:0] w, input logic [63:0] n);
    @(posedge pclk);
    trap_taken        <= 1'b1;
    trap_is_gpf       <= g;
    trap_report_gpa   <= r;
    trap_implicit     <= m;
    trap_gpa_access   <= a;
    trap_gpa_implicit <= w;
    trap_inst_info    <= n;
    @(posedge pclk);
    trap_taken        <= 1'b0;
    trap_is_gpf       <= ~g;
    trap_gpa_access   <= ~a;
    trap_gpa_implicit <= ~w;
    trap_inst_info    <= ~n;
  endtask : fire
endmodule : htx_trap_src

/* File: bench/htx_regs_tb.sv */
`timescale 1ns/1ps
module htx_regs_tb;
  import htx_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, illegal_instr, xlat_active, xlat_direct;
  logic [31:0] prdata;
  logic        access_from_hs = 1'b0;
  logic        trap_translation_access = 1'b0;
  logic        eff_priv_user = 1'b0;
  logic        hyp_user_access = 1'b0;
  logic        t_tk, t_gpf, t_rep, t_imp;
  logic [63:0] t_acc, t_impl, t_inst;
  htx_scheme_t xlat_scheme;
  logic [3:0]  xlat_mode;
  logic [13:0] xlat_machine_tag;
  logic [43:0] xlat_root_frame_number;
  logic [31:0] q;
  logic        e;
  int          n_fail = 0;
  int          samples_checked = 0;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  htx_trap_src i_src (.pclk(pclk), .trap_taken(t_tk), .trap_is_gpf(t_gpf), .trap_report_gpa(t_rep),
    .trap_implicit(t_imp), .trap_gpa_access(t_acc), .trap_gpa_implicit(t_impl), .trap_inst_info(t_inst));

  htx_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .access_from_hs(access_from_hs), .trap_translation_access(trap_translation_access),
    .illegal_instr(illegal_instr), .trap_taken(t_tk), .trap_is_gpf(t_gpf), .trap_report_gpa(t_rep),
    .trap_implicit(t_imp), .trap_gpa_access(t_acc), .trap_gpa_implicit(t_impl),
    .trap_inst_info(t_inst), .eff_priv_user(eff_priv_user), .hyp_user_access(hyp_user_access),
    .xlat_active(xlat_active), .xlat_direct(xlat_direct), .xlat_scheme(xlat_scheme),
    .xlat_mode(xlat_mode), .xlat_machine_tag(xlat_machine_tag),
    .xlat_root_frame_number(xlat_root_frame_number));

  // Verdict and end of run
  task automatic stop_test();
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, bounded wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n == 20)
    begin
      n_fail++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Trap value on plain, guest-fault and implicit guest-fault traps; instruction info on the two guest faults
  task automatic t_trap();
    apb(1'b1, OFS_TVAL_HI, 32'hffffffff);
    apb(1'b0, OFS_TVAL_HI, 32'h0);
    chk(q, 32'h01ffffff);
    i_src.fire(1'b1, 1'b1, 1'b0, 64'h0123456789abcdef, 64'h5555, 64'hfeedface12345678);
    apb(1'b0, OFS_TVAL_LO, 32'h0);
    chk(q, 32'he26af37b);
    apb(1'b0, OFS_TVAL_HI, 32'h0);
    chk(q, 32'h0048d159);
    apb(1'b0, OFS_TINST_HI, 32'h0);
    chk(q, 32'hfeedface);
    i_src.fire(1'b1, 1'b1, 1'b1, 64'h0123456789abcdef, 64'h1234, 64'h0);
    apb(1'b0, OFS_TVAL_LO, 32'h0);
    chk(q, 32'h0000048d);
    apb(1'b0, OFS_TINST_LO, 32'h0);
    chk(q, 32'h0);
    i_src.fire(1'b0, 1'b1, 1'b0, 64'hffffffffffffffff, 64'h1234, 64'h0);
    apb(1'b0, OFS_TVAL_LO, 32'h0);
    chk(q, 32'h0);
  endtask : t_trap

  // Root layout, tag probe, each supported mode code and one unsupported code
  task automatic t_root();
    logic [3:0]  md [4] = '{4'h0, 4'h9, 4'ha, 4'h3};
    logic [3:0]  em [4] = '{4'h0, 4'h9, 4'ha, 4'ha};
    htx_scheme_t sc [4] = '{XL_NONE, XL_P50, XL_P59, XL_P59};
    apb(1'b1, OFS_ROOT_LO, 32'hffffffff);
    apb(1'b1, OFS_ROOT_HI, 32'h8fffffff);
    apb(1'b0, OFS_ROOT_LO, 32'h0);
    chk(q, 32'hfffffffc);
    apb(1'b0, OFS_ROOT_HI, 32'h0);
    chk(q, 32'h83ffffff);
    chk(xlat_scheme, XL_P41);
    chk(xlat_root_frame_number, 44'hffffffffffc);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFS_ROOT_HI, {md[i], 28'h0005000});
      @(posedge pclk);
      chk(xlat_mode, em[i]);
      chk(xlat_scheme, sc[i]);
      chk(xlat_machine_tag, 14'h5);
      chk(xlat_direct, i == 0);
    end
  endtask : t_root

  // Gated root access and unmapped address
  task automatic t_gate();
    logic seen;
    seen = 1'b0;
    access_from_hs          <= 1'b1;
    trap_translation_access <= 1'b1;
    apb(1'b1, OFS_ROOT_LO, 32'h0);
    chk(e, 1'b1);
    repeat (2)
    begin
      @(posedge pclk);
      seen = seen | illegal_instr;
    end
    chk(seen, 1'b1);
    apb(1'b0, OFS_ROOT_LO, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    trap_translation_access <= 1'b0;
    apb(1'b0, OFS_ROOT_LO, 32'h0);
    chk({e, q}, {1'b0, 32'hfffffffc});
    apb(1'b0, 8'h18, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
  endtask : t_gate

  // Root active unless user level without access
  task automatic t_active();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      eff_priv_user   <= i[1];
      hyp_user_access <= i[0];
      repeat (2) @(posedge pclk);
      chk(xlat_active, !(i[1] && !i[0]));
    end
  endtask : t_active

  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(xlat_direct, 1'b1);
    t_trap();
    t_root();
    t_gate();
    t_active();
    stop_test();
  end
endmodule : htx_regs_tb
